// *** src/asx_conv_timer.sv ***
// Conversion-time counter on the conversion clock
`timescale 1ns/1ps
`include "asx_regs.svh"
module asx_conv_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  // ****************************************************************
  // Busy for exactly the conversion length
  // ****************************************************************
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start_in && !busy_q) begin
      busy_d = 1'b1;
      cnt_d = 6'h00;
    end else if (busy_q) begin
      if (cnt_q == `ASX_CONV_LAST) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + `ASX_CONV_ONE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;

endmodule : asx_conv_timer

// *** src/asx_exchange.sv ***
// Serial exchange and conversion sequencer of a sampling converter
//
// Overview of operation
// R01: Result output valid two conversion clocks after select.
// R02: Output leaves high impedance after second clock edge.
// R03: Host waits two clocks plus 100 ns.
// R04: Sample input for seven shift clocks, then hold.
// R05: Host keeps select high 52 clocks converting.
// R06: Result bits change only after falling shift edge.
// R07: Configuration bits sampled on rising shift edges.
// R08: Take first eight bits, ignore the rest.
// R09: Each exchange returns the previous conversion result.
// R10: Ignore control inputs for two clock edges.
// R11: Conversion starts when select returns high.
`timescale 1ns/1ps
`include "asx_regs.svh"
module asx_exchange (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  input wire logic [11:0] conv_code_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic sample_out,
  output logic conv_busy_out,
  output logic conv_start_out,
  output logic [7:0] cfg_word_out,
  output logic frame_err_out
);

  // ****************************************************************
  // Crossings into the conversion-clock domain
  // ****************************************************************
  asx_pkg::asx_link_type link_q;
  logic [1:0] raw_lvl;
  logic [1:0] sync_lvl;
  logic cs_s;
  logic cfg_full_s;

  assign raw_lvl = {link_q.full, cs_n_in};

  // ****************************************************************
  // Two-flop synchronisers, reset to each line's idle level
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      asx_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rst_val_in(gi == 0 ? 1'b1 : 1'b0),
        .async_in(raw_lvl[gi]),
        .sync_out(sync_lvl[gi])
      );
    end
  endgenerate

  assign cs_s = sync_lvl[0];
  assign cfg_full_s = sync_lvl[1];

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  logic conv_start_q;
  logic conv_start_d;
  logic conv_busy;
  logic conv_done;

  asx_conv_timer u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(conv_start_q),
    .busy_out(conv_busy),
    .done_out(conv_done)
  );

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  asx_pkg::asx_state_type state_q;
  asx_pkg::asx_state_type state_d;
  logic [1:0] arm_cnt_q;
  logic [1:0] arm_cnt_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic cfg_got_q;
  logic cfg_got_d;
  logic cfg_prev_q;
  logic cfg_prev_d;
  logic cs_prev_q;
  logic cs_prev_d;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic oe_q;
  logic oe_d;
  logic err_q;
  logic err_d;
  logic cfg_new;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************

  always_comb begin
    state_d = state_q;
    arm_cnt_d = arm_cnt_q;
    cfg_d = cfg_q;
    cfg_got_d = cfg_got_q;
    result_d = result_q;
    oe_d = oe_q;
    err_d = 1'b0;
    conv_start_d = 1'b0;
    cfg_prev_d = cfg_full_s;
    cs_prev_d = cs_s;
    cfg_new = cfg_full_s & ~cfg_prev_q & ~cfg_got_q;
    // Result lands only at conversion end, never mid-frame
    if (conv_done) begin
      result_d = conv_code_in; // R09
    end
    unique case (state_q)
      asx_pkg::st_idle: begin
        oe_d = 1'b0;
        // Select already low after a late conversion still counts
        if (!cs_s && !conv_busy) begin
          state_d = asx_pkg::st_arm;
          arm_cnt_d = 2'h0;
          cfg_got_d = 1'b0;
        end
      end
      asx_pkg::st_arm: begin
        // Short glitches on select die here, flagging a frame error
        if (cs_s) begin
          state_d = asx_pkg::st_idle; // R10
          err_d = 1'b1;
        end else if (arm_cnt_q == `ASX_ARM_LAST) begin
          state_d = asx_pkg::st_xfer; // R10
          oe_d = 1'b1; // R01 R02
        end else begin
          arm_cnt_d = arm_cnt_q + `ASX_ARM_ONE; // R01
        end
      end
      asx_pkg::st_xfer: begin
        if (cfg_new) begin
          cfg_d = link_q.word; // R08
          cfg_got_d = 1'b1;
        end
        if (cs_s) begin
          oe_d = 1'b0;
          if (cfg_got_q || cfg_new) begin
            state_d = asx_pkg::st_conv;
            conv_start_d = 1'b1; // R11
          end else begin
            state_d = asx_pkg::st_idle;
            err_d = 1'b1;
          end
        end
      end
      asx_pkg::st_conv: begin
        oe_d = 1'b0;
        // Select low here breaks the high-time duty; flag it
        if (!cs_s && cs_prev_q) begin
          err_d = 1'b1; // R05
        end
        if (conv_done) begin
          state_d = asx_pkg::st_idle;
        end
      end
      default: begin
        state_d = asx_pkg::st_idle;
        oe_d = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= asx_pkg::st_idle;
      arm_cnt_q <= 2'h0;
      cfg_q <= `ASX_CFG_RST;
      cfg_got_q <= 1'b0;
      cfg_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      result_q <= `ASX_RES_RST;
      oe_q <= 1'b0;
      err_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      arm_cnt_q <= arm_cnt_d;
      cfg_q <= cfg_d;
      cfg_got_q <= cfg_got_d;
      cfg_prev_q <= cfg_prev_d;
      cs_prev_q <= cs_prev_d;
      result_q <= result_d;
      oe_q <= oe_d;
      err_q <= err_d;
      conv_start_q <= conv_start_d;
    end
  end

  // ****************************************************************
  // Shift-clock side, rising edges: configuration and sampling
  // ****************************************************************
  // Chip select high clears this side; the clock may stop between
  // frames, so nothing here relies on edges outside a frame.
  logic [3:0] rise_cnt_q;
  logic [3:0] rise_cnt_d;
  logic [7:0] cfg_sr_q;
  logic [7:0] cfg_sr_d;
  logic sample_q;
  logic sample_d;

  always_comb begin
    rise_cnt_d = rise_cnt_q;
    cfg_sr_d = cfg_sr_q;
    if (rise_cnt_q < `ASX_CFG_BITS) begin
      cfg_sr_d = {cfg_sr_q[6:0], din_in}; // R07 R08
    end
    if (rise_cnt_q != `ASX_CNT_MAX) begin
      rise_cnt_d = rise_cnt_q + `ASX_CNT_ONE;
    end
    sample_d = (rise_cnt_d >= `ASX_SMPL_START) &&
               (rise_cnt_d < `ASX_SMPL_END); // R04
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rise_cnt_q <= 4'h0;
      cfg_sr_q <= `ASX_CFG_RST;
      sample_q <= 1'b0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      cfg_sr_q <= cfg_sr_d;
      sample_q <= sample_d;
    end
  end

  // ****************************************************************
  // Configuration word hand-off
  // ****************************************************************
  // Word is stable once full is seen, until select rises
  always_comb begin
    link_q.word = cfg_sr_q;
    link_q.full = (rise_cnt_q >= `ASX_CFG_BITS); // R08
  end

  // ****************************************************************
  // Shift-clock side, falling edges: result bit index
  // ****************************************************************
  logic [3:0] fall_cnt_q;
  logic [3:0] fall_cnt_d;

  always_comb begin
    fall_cnt_d = fall_cnt_q;
    if (fall_cnt_q < `ASX_RES_BITS) begin
      fall_cnt_d = fall_cnt_q + `ASX_CNT_ONE; // R06
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fall_cnt_q <= 4'h0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
    end
  end

  // ****************************************************************
  // Result pin
  // ****************************************************************
  // The result word is quasi-static: it only changes when a conversion
  // finishes, while the output is disabled, so the mux needs no crossing.
  asx_pkg::asx_pin_type pin;
  logic [3:0] bit_idx;

  always_comb begin
    bit_idx = `ASX_RES_MSB - fall_cnt_q;
    pin.oe = oe_q; // R02
    if (fall_cnt_q < `ASX_RES_BITS) begin
      pin.data = result_q[bit_idx]; // R06 R09
    end else begin
      pin.data = 1'b0;
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  assign dout_out = pin.data;
  assign dout_oe_out = pin.oe;
  assign sample_out = sample_q;
  assign conv_busy_out = conv_busy;
  assign conv_start_out = conv_start_q;
  assign cfg_word_out = cfg_q;
  assign frame_err_out = err_q;

endmodule : asx_exchange

// *** src/asx_pkg.sv ***
// Types shared by the serial exchange sequencer
package asx_pkg;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_arm = 4'h2,
    st_xfer = 4'h4,
    st_conv = 4'h8
  } asx_state_type;

  // ****************************************************************
  // Configuration word handed from the shift-clock side
  // ****************************************************************
  typedef struct packed {
    logic full;
    logic [7:0] word;
  } asx_link_type;

  // ****************************************************************
  // Serial result pin
  // ****************************************************************
  typedef struct packed {
    logic data;
    logic oe;
  } asx_pin_type;

endpackage : asx_pkg

// *** src/asx_regs.svh ***
// Named constants of the converter serial exchange sequencer
`ifndef ASX_REGS_SVH
`define ASX_REGS_SVH

// ****************************************************************
// Exchange framing
// ****************************************************************
`define ASX_CFG_BITS 4'h8
`define ASX_RES_BITS 4'hC
`define ASX_RES_MSB 4'hB
`define ASX_CNT_MAX 4'hF
`define ASX_CNT_ONE 4'h1

// ****************************************************************
// Sample window, counted in rising shift-clock edges
// ****************************************************************
`define ASX_SMPL_START 4'h4
`define ASX_SMPL_CYCLES 4'h7
`define ASX_SMPL_END (`ASX_SMPL_START + `ASX_SMPL_CYCLES)

// ****************************************************************
// Conversion-clock timing
// ****************************************************************
`define ASX_ARM_EDGES 2'h2
`define ASX_ARM_LAST (`ASX_ARM_EDGES - 2'h1)
`define ASX_ARM_ONE 2'h1
`define ASX_CONV_CYCLES 6'h34
`define ASX_CONV_LAST (`ASX_CONV_CYCLES - 6'h01)
`define ASX_CONV_ONE 6'h01

// ****************************************************************
// Reset values
// ****************************************************************
`define ASX_CFG_RST 8'h00
`define ASX_RES_RST 12'h000

`endif

// *** src/asx_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
module asx_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rst_val_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ****************************************************************
  // First flop feeds only the second
  // ****************************************************************
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  // Reset to the idle level, so no false edge follows reset
  assign sync_out = sync_q;

endmodule : asx_sync

// *** tb/asx_exchange_bench.sv ***
// Self-checking bench of the serial exchange sequencer
`timescale 1ns/1ps
module asx_exchange_bench;
  logic clk_in;
  logic rst_in;
  logic sclk;
  logic cs_n;
  logic din;
  logic [11:0] code;
  logic dout;
  logic oe;
  logic busy;
  logic start;
  logic [7:0] cfg_word;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  asx_exchange asx_exchange_inst (.clk_in(clk_in), .rst_in(rst_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .conv_code_in(code),
    .dout_out(dout), .dout_oe_out(oe), .sample_out(),
    .conv_busy_out(busy), .conv_start_out(start),
    .cfg_word_out(cfg_word), .frame_err_out(err));
  asx_host asx_host_inst (.clk_in(clk_in), .dout_in(dout),
    .dout_oe_in(oe), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ****
  // Checking and reporting
  // ****
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic watch_conv;
    int n;
    n = 0;
    while (start !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 300) begin
      num_errors++;
      summarize();
    end
    chk({11'h000, cs_n}, 12'h001);
    n = 0;
    @(negedge clk_in);
    while (busy === 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    chk(12'(n), 12'h034);
  endtask : watch_conv
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    chk({oe, busy, start, dout, cfg_word}, 12'h000);
  endtask : t_reset
  task automatic t_frame(input logic [7:0] cfg, input int nclk,
      input logic [11:0] prev, input logic [11:0] nxt);
    logic [11:0] res;
    logic oe_ok;
    @(negedge clk_in);
    code = nxt;
    fork
      asx_host_inst.frame(cfg, nclk, res, oe_ok);
      watch_conv();
    join
    chk({11'h000, oe_ok}, 12'h001);
    chk(res, prev);
    chk({4'h0, cfg_word}, {4'h0, cfg});
  endtask : t_frame
  task automatic t_short(input logic [11:0] prev, input logic [7:0] keep);
    logic [11:0] res;
    logic oe_ok;
    int errs;
    int starts;
    errs = 0;
    starts = 0;
    @(negedge clk_in);
    fork
      asx_host_inst.frame(8'hF0, 4, res, oe_ok);
      repeat (150) begin
        @(negedge clk_in);
        errs += int'(err === 1'b1);
        starts += int'(start === 1'b1);
      end
    join
    chk({11'h000, oe_ok}, 12'h001);
    chk(12'(errs), 12'h001);
    chk(12'(starts), 12'h000);
    chk(res, {8'h00, prev[11:8]});
    chk({4'h0, cfg_word}, {4'h0, keep});
  endtask : t_short
  initial begin
    rst_in = 1'b1;
    code = 12'h000;
    repeat (10) @(negedge clk_in);
    t_reset();
    rst_in = 1'b0;
    t_frame(8'hA5, 12, 12'h000, 12'hABC);
    // Extra bits beyond the word must be ignored
    t_frame(8'h3C, 16, 12'hABC, 12'h5A3);
    // Frame cut short: no conversion, result and word kept
    t_short(12'h5A3, 8'h3C);
    t_frame(8'h81, 12, 12'h5A3, 12'h000);
    summarize();
  end
endmodule : asx_exchange_bench

// *** tb/asx_exchange_chk.sv ***
// Checker of the serial exchange sequencer
`timescale 1ns/1ps
module asx_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic dout_out,
  input wire logic dout_oe_out,
  input wire logic sample_out,
  input wire logic conv_busy_out,
  input wire logic conv_start_out,
  input wire logic [7:0] cfg_word_out
);
  // ****
  // Busy length counter
  // ****
  logic [6:0] busy_q;
  logic [6:0] busy_d;
  always_comb begin
    busy_d = conv_busy_out ? busy_q + 7'h01 : 7'h00;
  end
  always_ff @(posedge clk_in) begin
    busy_q <= rst_in ? 7'h00 : busy_d;
  end
  oe_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(cs_n_in) |-> !dout_oe_out [*3]) else $error("oe early");
  oe_rise_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(cs_n_in) && !conv_busy_out |-> ##[3:7] dout_oe_out)
    else $error("oe late");
  oe_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(cs_n_in) |-> ##[1:5] !dout_oe_out) else $error("oe stuck");
  conv_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(conv_busy_out) |-> busy_q == 7'h34) else $error("busy len");
  start_busy_a: assert property (@(posedge clk_in) disable iff (rst_in)
    conv_start_out |-> cs_n_in ##1 conv_busy_out) else $error("start");
  word_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(cfg_word_out) |-> !cs_n_in && !conv_busy_out)
    else $error("word moved");
  dout_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    dout_oe_out && $past(dout_oe_out) && sclk_in && $past(sclk_in)
    |-> $stable(dout_out)) else $error("dout moved");
  sample_len_a: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    $rose(sample_out) |-> sample_out [*7] ##1 !sample_out)
    else $error("sample len");
  cover property (@(posedge clk_in) conv_start_out);
  cover property (@(posedge clk_in) $fell(conv_busy_out));
  cover property (@(posedge sclk_in) $rose(sample_out));
endmodule : asx_chk
bind asx_exchange asx_chk asx_chk_inst (.clk_in, .rst_in, .sclk_in,
  .cs_n_in, .dout_out, .dout_oe_out, .sample_out, .conv_busy_out,
  .conv_start_out, .cfg_word_out);

// *** tb/asx_host.sv ***
// Host serial port model of the converter link
`timescale 1ns/1ps
module asx_host (
  input wire logic clk_in,
  input wire logic dout_in,
  input wire logic dout_oe_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out
);
  initial begin
    cs_n_out = 1'b0;
    sclk_out = 1'b0;
    din_out = 1'b0;
    // Rising select at start clears the shift-clock side
    #1;
    cs_n_out = 1'b1;
  end
  // ****
  // One frame; shift clock stands low between frames
  // ****
  task automatic frame(input logic [7:0] cfg, input int nclk,
      output logic [11:0] res, output logic oe_ok);
    res = 12'h000;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (7) @(negedge clk_in);
    oe_ok = dout_oe_in;
    #103;
    for (int i = 0; i < nclk; i++) begin
      din_out = (i < 8) ? cfg[3'h7 - i[2:0]] : ~din_out;
      #40;
      if (i < 12) begin
        res = {res[10:0], dout_in};
      end
      sclk_out = 1'b1;
      #40;
      sclk_out = 1'b0;
    end
    #80;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    din_out = ~din_out;
    repeat (60) @(negedge clk_in);
  endtask : frame
endmodule : asx_host
